// ### dmrt_pkg.sv
// What this block does
// - 16-bit counter from two byte halves
// - Mode from split and capture enable bits
// - Count clock: system, div twelve, ext div8
// - Synchronize external div8 tick to clock
// - 16-bit mode: count up, reload on rollover
// - 16-bit rollover sets high flag, interrupts
// - Low byte wrap interrupts when enabled
// - Split: two 8-bit timers, own reloads
// - Split: run control gates high only
// - Per-byte clock select with external select
// - Split: each byte wrap sets its flag
// - Split interrupts: high, either if enabled
// - Flags cleared only by software
// - Capture copies count into reload, interrupts
//
// Purpose: Constants for the dual mode reload timer
// Assumes: 32-bit AXI4-Lite, one register per word
// Notes:   Narrow registers sit in the low bits
package dmrt_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CONTROL  = 5'h00;
    localparam logic [4:0] OFS_CLKCTL   = 5'h04;
    localparam logic [4:0] OFS_CNT_LO   = 5'h08;
    localparam logic [4:0] OFS_CNT_HI   = 5'h0c;
    localparam logic [4:0] OFS_RLD_LO   = 5'h10;
    localparam logic [4:0] OFS_RLD_HI   = 5'h14;
    localparam logic [4:0] OFS_INTEN    = 5'h18;
    // Control register fields
    localparam int BIT_HIGH_FLAG   = 7;
    localparam int BIT_LOW_FLAG    = 6;
    localparam int BIT_LOW_INT_EN  = 5;
    localparam int BIT_CAPTURE_EN  = 4;
    localparam int BIT_SPLIT       = 3;
    localparam int BIT_RUN         = 2;
    localparam int BIT_CAP_SRC     = 1;
    localparam int BIT_EXT_SEL     = 0;
    // Clock control register fields
    localparam int BIT_HIGH_CLKSEL = 5;
    localparam int BIT_LOW_CLKSEL  = 4;
    // Interrupt enable register field
    localparam int BIT_TIMER_INTEN = 0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Prescalers
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [2:0] DIV8_LAST  = 3'h7;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Operating modes: {capture_enable, split}
    typedef enum logic [1:0] {
        DMRT_MODE_RLD16  = 2'b00,
        DMRT_MODE_RLD8X2 = 2'b01,
        DMRT_MODE_CAP16  = 2'b10,
        DMRT_MODE_CAP8X2 = 2'b11
    } dmrt_mode_t;
endpackage

// ### dmrt_timer.sv
// Purpose: Dual mode reload timer with AXI4-Lite registers
// Assumes: All inputs synchronous except ext_osc and slow_osc
// Notes:   Write 0 to a flag to clear it; hardware set wins
`timescale 1ns/100ps
module dmrt_timer
    import dmrt_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [4:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [4:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Clock sources and capture events
    input  wire logic        ext_osc,
    input  wire logic        slow_osc,
    input  wire logic        sof_event,
    // Interrupt request
    output logic             timer_irq
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [7:0]  clkctl_r;
    logic        timer_inten_r;
    logic [7:0]  count_low_byte_r, count_low_nxt;
    logic [7:0]  count_high_byte_r, count_high_nxt;
    logic [7:0]  reload_low_byte_r, reload_low_nxt;
    logic [7:0]  reload_high_byte_r, reload_high_nxt;
    logic        bvalid_r, rvalid_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [3:0]  div12_r;
    logic        ext_s1_r, ext_s2_r, ext_s3_r;
    logic [2:0]  div8_r;
    logic        slow_s1_r, slow_s2_r, slow_s3_r;

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    wire rd_fire = s_axi_arvalid & ~rvalid_r;
    wire wr_lane = wr_fire & s_axi_wstrb[0];
    wire [7:0] wbyte = s_axi_wdata[7:0];
    wire wr_ctrl   = wr_lane & (s_axi_awaddr == OFS_CONTROL);
    wire wr_clkctl = wr_lane & (s_axi_awaddr == OFS_CLKCTL);
    wire wr_cnt_lo = wr_lane & (s_axi_awaddr == OFS_CNT_LO);
    wire wr_cnt_hi = wr_lane & (s_axi_awaddr == OFS_CNT_HI);
    wire wr_rld_lo = wr_lane & (s_axi_awaddr == OFS_RLD_LO);
    wire wr_rld_hi = wr_lane & (s_axi_awaddr == OFS_RLD_HI);
    wire wr_inten  = wr_lane & (s_axi_awaddr == OFS_INTEN);
    wire wr_mapped = (s_axi_awaddr[1:0] == 2'b00)
                   & (s_axi_awaddr <= OFS_INTEN);
    wire rd_mapped = (s_axi_araddr[1:0] == 2'b00)
                   & (s_axi_araddr <= OFS_INTEN);
    wire [7:0] rd_byte =
        (s_axi_araddr == OFS_CONTROL) ? ctrl_r :
        (s_axi_araddr == OFS_CLKCTL)  ? clkctl_r :
        (s_axi_araddr == OFS_CNT_LO)  ? count_low_byte_r :
        (s_axi_araddr == OFS_CNT_HI)  ? count_high_byte_r :
        (s_axi_araddr == OFS_RLD_LO)  ? reload_low_byte_r :
        (s_axi_araddr == OFS_RLD_HI)  ? reload_high_byte_r :
        (s_axi_araddr == OFS_INTEN)   ? {7'h00, timer_inten_r} : 8'h00;

    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = rd_fire;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    ////////////////////////////////////////////////////////////////////
    // Mode and clock selection
    wire split_select   = ctrl_r[BIT_SPLIT];
    wire capture_enable = ctrl_r[BIT_CAPTURE_EN];
    wire run_control    = ctrl_r[BIT_RUN];
    wire ext_select     = ctrl_r[BIT_EXT_SEL];
    wire low_int_enable = ctrl_r[BIT_LOW_INT_EN];
    dmrt_mode_t mode;
    assign mode = dmrt_mode_t'({capture_enable, split_select});

    wire div12_tick = (div12_r == DIV12_LAST);
    wire ext_edge   = ext_s2_r & ~ext_s3_r;
    wire ext_tick   = ext_edge & (div8_r == DIV8_LAST);
    wire slow_fall  = ~slow_s2_r & slow_s3_r;
    wire slow_tick  = ext_select ? ext_tick : div12_tick;
    wire tick_low   = clkctl_r[BIT_LOW_CLKSEL] ? 1'b1 : slow_tick;
    wire tick_high  = clkctl_r[BIT_HIGH_CLKSEL] ? 1'b1 : slow_tick;
    wire cap_event  = ctrl_r[BIT_CAP_SRC] ? slow_fall : sof_event;

    ////////////////////////////////////////////////////////////////////
    // Counter datapath
    logic adv_low, adv_high, wrap_low, wrap_high, cap_hit;
    always_comb begin
        cap_hit         = 1'b0;
        reload_low_nxt  = reload_low_byte_r;
        reload_high_nxt = reload_high_byte_r;
        case (mode)
            DMRT_MODE_RLD16, DMRT_MODE_CAP16: begin
                adv_low  = run_control & tick_low;
                adv_high = adv_low & (count_low_byte_r == 8'hff);
            end
            DMRT_MODE_RLD8X2, DMRT_MODE_CAP8X2: begin
                adv_low  = tick_low;
                adv_high = run_control & tick_high;
            end
            default: {adv_low, adv_high} = 2'b00;
        endcase
        wrap_low       = adv_low & (count_low_byte_r == 8'hff);
        wrap_high      = adv_high & (count_high_byte_r == 8'hff);
        count_low_nxt  = count_low_byte_r + {7'h00, adv_low};
        count_high_nxt = count_high_byte_r + {7'h00, adv_high};
        if (!capture_enable) begin
            if (split_select) begin
                if (wrap_low) begin
                    count_low_nxt = reload_low_byte_r;
                end
                if (wrap_high) begin
                    count_high_nxt = reload_high_byte_r;
                end
            end else if (wrap_high) begin
                count_low_nxt  = reload_low_byte_r;
                count_high_nxt = reload_high_byte_r;
            end
        end else if (cap_event) begin
            cap_hit         = 1'b1;
            reload_low_nxt  = count_low_byte_r;
            reload_high_nxt = count_high_byte_r;
        end
        count_low_nxt   = wr_cnt_lo ? wbyte : count_low_nxt;
        count_high_nxt  = wr_cnt_hi ? wbyte : count_high_nxt;
        reload_low_nxt  = wr_rld_lo ? wbyte : reload_low_nxt;
        reload_high_nxt = wr_rld_hi ? wbyte : reload_high_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Control register and flags, hardware set beats software clear
    wire set_high = (wrap_high & ~capture_enable) | cap_hit;
    wire set_low  = wrap_low & ~capture_enable;
    always_comb begin
        ctrl_nxt = wr_ctrl ? wbyte : ctrl_r;
        if (set_high) begin
            ctrl_nxt[BIT_HIGH_FLAG] = 1'b1;
        end
        if (set_low) begin
            ctrl_nxt[BIT_LOW_FLAG] = 1'b1;
        end
    end

    // Either flag can be the source; software reads both
    assign timer_irq = timer_inten_r & (ctrl_r[BIT_HIGH_FLAG]
                     | (ctrl_r[BIT_LOW_FLAG] & low_int_enable));

    ////////////////////////////////////////////////////////////////////
    // Timer state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r             <= RST_BYTE;
            clkctl_r           <= RST_BYTE;
            timer_inten_r      <= 1'b0;
            count_low_byte_r   <= RST_BYTE;
            count_high_byte_r  <= RST_BYTE;
            reload_low_byte_r  <= RST_BYTE;
            reload_high_byte_r <= RST_BYTE;
        end else begin
            ctrl_r             <= ctrl_nxt;
            count_low_byte_r   <= count_low_nxt;
            count_high_byte_r  <= count_high_nxt;
            reload_low_byte_r  <= reload_low_nxt;
            reload_high_byte_r <= reload_high_nxt;
            clkctl_r           <= wr_clkctl ? wbyte : clkctl_r;
            timer_inten_r <= wr_inten ? wbyte[BIT_TIMER_INTEN] : timer_inten_r;
        end
    end

    // Prescalers and synchronizers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div12_r   <= 4'h0;
            div8_r    <= 3'h0;
            ext_s1_r  <= 1'b0;
            ext_s2_r  <= 1'b0;
            ext_s3_r  <= 1'b0;
            slow_s1_r <= 1'b0;
            slow_s2_r <= 1'b0;
            slow_s3_r <= 1'b0;
        end else begin
            div12_r   <= div12_tick ? 4'h0 : div12_r + 4'h1;
            ext_s1_r  <= ext_osc;
            ext_s2_r  <= ext_s1_r;
            ext_s3_r  <= ext_s2_r;
            slow_s1_r <= slow_osc;
            slow_s2_r <= slow_s1_r;
            slow_s3_r <= slow_s2_r;
            div8_r    <= div8_r + {2'b00, ext_edge};
        end
    end

    // Bus response
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else begin
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                rdata_r  <= {24'h000000, rd_byte};
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    wire quiet = ~wr_fire;
    wire m16   = (mode == DMRT_MODE_RLD16);
    wire m8    = (mode == DMRT_MODE_RLD8X2);
    wire run16 = m16 && quiet && run_control && tick_low;

    property p_div12;
        div12_tick |=> !div12_tick [*8];
    endproperty
    a_div12: assert property (p_div12)
        else $error("div twelve tick too early");
    property p_ext_sync;
        ext_tick |-> $past(ext_osc, 2) && !$past(ext_osc, 3);
    endproperty
    a_ext_sync: assert property (p_ext_sync)
        else $error("external tick without synchronized edge");
    property p_reload16;
        run16 && {count_high_byte_r, count_low_byte_r} == 16'hffff
        |=> {count_high_byte_r, count_low_byte_r}
            == {$past(reload_high_byte_r), $past(reload_low_byte_r)};
    endproperty
    a_reload16: assert property (p_reload16)
        else $error("16-bit rollover did not reload");
    property p_flag16;
        run16 && {count_high_byte_r, count_low_byte_r} == 16'hffff
            && timer_inten_r
        |=> ctrl_r[BIT_HIGH_FLAG] && timer_irq;
    endproperty
    a_flag16: assert property (p_flag16)
        else $error("16-bit rollover flag or interrupt missing");
    property p_low16;
        run16 && count_low_byte_r == 8'hff && low_int_enable
            && timer_inten_r
        |=> ctrl_r[BIT_LOW_FLAG] && timer_irq;
    endproperty
    a_low16: assert property (p_low16)
        else $error("low byte wrap did not interrupt");
    property p_split_reload;
        m8 && quiet && tick_low && count_low_byte_r == 8'hff
        |=> count_low_byte_r == $past(reload_low_byte_r);
    endproperty
    a_split_reload: assert property (p_split_reload)
        else $error("split low byte did not reload");
    property p_low_free;
        m8 && quiet && !run_control && tick_low
            && count_low_byte_r != 8'hff
        |=> count_low_byte_r == $past(count_low_byte_r) + 8'h01;
    endproperty
    a_low_free: assert property (p_low_free)
        else $error("split low byte stopped by run control");
    property p_high_stop;
        m8 && quiet && !run_control
        |=> count_high_byte_r == $past(count_high_byte_r);
    endproperty
    a_high_stop: assert property (p_high_stop)
        else $error("split high byte ran while stopped");
    property p_split_flag;
        m8 && quiet && run_control && tick_high
            && count_high_byte_r == 8'hff && timer_inten_r
        |=> ctrl_r[BIT_HIGH_FLAG] && timer_irq;
    endproperty
    a_split_flag: assert property (p_split_flag)
        else $error("split high wrap flag or interrupt missing");
    property p_sticky;
        ctrl_r[BIT_HIGH_FLAG] && quiet |=> ctrl_r[BIT_HIGH_FLAG];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("high flag cleared by hardware");
    property p_capture;
        capture_enable && cap_event && quiet
        |=> reload_low_byte_r == $past(count_low_byte_r)
            && reload_high_byte_r == $past(count_high_byte_r)
            && ctrl_r[BIT_HIGH_FLAG];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not latch the count");
    property p_irq_gate;
        !timer_inten_r |-> !timer_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

    c_reload16: cover property (m16 && wrap_high);
    c_split_low: cover property (m8 && wrap_low && !run_control);
    c_capture: cover property (capture_enable && cap_event);
    c_ext: cover property (ext_tick && tick_low);
endmodule

// ### dmrt_timer_bench.sv
// Purpose: Self-checking bench for the dual mode reload timer
// Assumes: Write and read answers come one cycle after acceptance
// Notes:   A quiet ext_osc with external select holds a counter still
`timescale 1ns/100ps
module dmrt_timer_bench
    import dmrt_pkg::*;
;
////////////////////////////////////////////////////////////////////////////
logic        clock         = 1'b0;
logic        sys_rst       = 1'b1;
logic        s_axi_awvalid = 1'b0;
logic [4:0]  s_axi_awaddr  = 5'h00;
logic        s_axi_wvalid  = 1'b0;
logic [31:0] s_axi_wdata   = 32'h0;
logic [3:0]  s_axi_wstrb   = 4'h0;
logic        s_axi_bready  = 1'b0;
logic        s_axi_arvalid = 1'b0;
logic [4:0]  s_axi_araddr  = 5'h00;
logic        s_axi_rready  = 1'b0;
logic        ext_osc       = 1'b0;
logic        slow_osc      = 1'b0;
logic        sof_event     = 1'b0;
logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic        s_axi_rvalid, timer_irq;
logic [1:0]  s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
logic [39:0] rq [$];
logic [1:0]  bq [$];
logic [39:0] e;
logic [7:0]  v [4];
int          mismatches    = 0;
int          tests_run     = 0;
// Control values with run off, and the interrupt each must give
localparam logic [31:0] CTL_TAB = 32'h2080_6040;
localparam logic [3:0]  IRQ_TAB = 4'b0110;

always #20 clock = ~clock;

dmrt_timer dut (
    .clock(clock), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .ext_osc(ext_osc), .slow_osc(slow_osc),
    .sof_event(sof_event), .timer_irq(timer_irq)
);
////////////////////////////////////////////////////////////////////////////
task automatic check(input string what, input logic [34:0] seen,
                     input logic [34:0] exp);
    tests_run++;
    if (seen !== exp) begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask

task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

task automatic lim(input int n);
    if (n >= 50) begin
        mismatches++;
        wrap_up();
    end
endtask

task automatic wrx(input logic [4:0] a, input logic [7:0] d,
                   input logic [3:0] strb, input logic [1:0] resp);
    int n;
    @(posedge clock);
    bq.push_back(resp);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= strb;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
        @(posedge clock);
        n++;
    end while ((s_axi_awready & s_axi_wready) !== 1'b1 && n < 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do begin
        @(posedge clock);
        n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    lim(n);
endtask

task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wrx(a, d, 4'hf, RESP_OKAY);
endtask

task automatic rdx(input logic [4:0] a, input logic [7:0] d,
                   input logic [1:0] resp, input logic irq);
    int n;
    @(posedge clock);
    rq.push_back({a, irq, resp, 24'h0, d});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
        @(posedge clock);
        n++;
    end while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
        @(posedge clock);
        n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    lim(n);
endtask

task automatic rd(input logic [4:0] a, input logic [7:0] d,
                  input logic irq);
    rdx(a, d, RESP_OKAY, irq);
endtask

// Counts low, high, then reloads low, high from one word
task automatic set4(input logic [31:0] vals);
    for (int i = 0; i < 4; i++)
        wr(5'(OFS_CNT_LO + 4 * i), vals[8 * i +: 8]);
endtask

task automatic ext_edges(input int k);
    repeat (k) begin
        repeat (3) @(posedge clock);
        ext_osc <= 1'b1;
        repeat (3) @(posedge clock);
        ext_osc <= 1'b0;
    end
    repeat (8) @(posedge clock);
endtask
////////////////////////////////////////////////////////////////////////////
// Answers are compared with the oldest note
always @(posedge clock) begin
    if (sys_rst === 1'b0 && (s_axi_rvalid & s_axi_rready) === 1'b1) begin
        e = rq.pop_front();
        check($sformatf("read %h", e[39:35]),
              {timer_irq, s_axi_rresp, s_axi_rdata}, e[34:0]);
    end
    if (sys_rst === 1'b0 && (s_axi_bvalid & s_axi_bready) === 1'b1)
        check("bresp", {33'h0, s_axi_bresp}, {33'h0, bq.pop_front()});
end
////////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(10));
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    // Reset values, unmapped place, byte halves
    for (int i = 0; i < 7; i++)
        rd(5'(i * 4), 8'h00, 1'b0);
    rdx(5'h1c, 8'h00, RESP_SLVERR, 1'b0);
    wrx(5'h1c, 8'hff, 4'hf, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
        v[i] = 8'($urandom());
        wr(5'(OFS_CNT_LO + 4 * i), v[i]);
        rd(5'(OFS_CNT_LO + 4 * i), v[i], 1'b0);
    end
    wrx(OFS_RLD_HI, ~v[3], 4'h0, RESP_OKAY);
    rd(OFS_RLD_HI, v[3], 1'b0);
    // Interrupt request gating
    wr(OFS_INTEN, 8'h01);
    for (int i = 0; i < 4; i++) begin
        wr(OFS_CONTROL, CTL_TAB[8 * i +: 8]);
        rd(OFS_CONTROL, CTL_TAB[8 * i +: 8], IRQ_TAB[i]);
    end
    wr(OFS_INTEN, 8'h00);
    wr(OFS_CONTROL, 8'h80);
    rd(OFS_CONTROL, 8'h80, 1'b0);
    wr(OFS_INTEN, 8'h01);
    rd(OFS_INTEN, 8'h01, 1'b1);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_CONTROL, 8'h00, 1'b0);
    // Split mode, low byte on external clock
    wr(OFS_CLKCTL, 8'h20);
    set4(32'h2211_fdfe);
    wr(OFS_CONTROL, 8'h09);
    rd(OFS_CNT_HI, 8'hfd, 1'b0);
    ext_edges(8);
    rd(OFS_CNT_LO, 8'hff, 1'b0);
    ext_edges(8);
    rd(OFS_CNT_LO, 8'h11, 1'b0);
    rd(OFS_CONTROL, 8'h49, 1'b0);
    rd(OFS_CNT_HI, 8'hfd, 1'b0);
    wr(OFS_CONTROL, 8'h0d);
    repeat (10) @(posedge clock);
    rd(OFS_CONTROL, 8'h8d, 1'b1);
    rd(OFS_RLD_HI, 8'h22, 1'b1);
    rd(OFS_CNT_LO, 8'h11, 1'b1);
    // 16-bit on system clock for exactly 240 ticks, low interrupt on
    wr(OFS_CONTROL, 8'h25);
    set4(32'h1234_fff0);
    wr(OFS_CLKCTL, 8'h10);
    repeat (237) @(posedge clock);
    wr(OFS_CLKCTL, 8'h00);
    rd(OFS_CNT_LO, 8'h14, 1'b1);
    rd(OFS_CNT_HI, 8'h13, 1'b1);
    rd(OFS_CONTROL, 8'he5, 1'b1);
    // Divide by twelve for 240 cycles
    set4(32'h1234_0000);
    wr(OFS_CONTROL, 8'h04);
    repeat (237) @(posedge clock);
    wr(OFS_CONTROL, 8'h05);
    rd(OFS_CNT_LO, 8'h14, 1'b0);
    rd(OFS_CNT_HI, 8'h00, 1'b0);
    // Capture from both event sources, the second in split mode
    for (int s = 0; s < 2; s++) begin
        v[0] = 8'($urandom());
        v[1] = 8'($urandom());
        set4({16'h0, v[1], v[0]});
        wr(OFS_CONTROL, 8'(8'h11 | (s * 10)));
        if (s == 0) begin
            sof_event <= 1'b1;
            @(posedge clock);
            sof_event <= 1'b0;
        end else begin
            slow_osc <= 1'b1;
            repeat (4) @(posedge clock);
            slow_osc <= 1'b0;
        end
        repeat (8) @(posedge clock);
        rd(OFS_RLD_LO, v[0], 1'b1);
        rd(OFS_RLD_HI, v[1], 1'b1);
        rd(OFS_CONTROL, 8'(8'h91 | (s * 10)), 1'b1);
        wr(OFS_CONTROL, 8'h05);
    end
    repeat (4) @(posedge clock);
    check("pending", {3'h0, 32'(rq.size())}, 35'h0);
    wrap_up();
end
endmodule
